// File: pkg/asdc_pkg.sv
/*
 * asdc_pkg: register map, field positions, reset values and state type
 * for the converter sleep/debug control block.
 * Assumes an 8-bit register port with byte addresses as listed here.
 */
package asdc_pkg;

    localparam logic [7:0] OFS_CTRL_ENABLE_SLEEP  = 8'h00;
    localparam logic [7:0] OFS_CLOCK_DIVIDER_CTRL = 8'h01;
    localparam logic [7:0] OFS_TIMEBASE_REF_CTRL  = 8'h02;
    localparam logic [7:0] OFS_WINDOW_CMP_CTRL    = 8'h03;
    localparam logic [7:0] OFS_INTERRUPT_ENABLE   = 8'h04;
    localparam logic [7:0] OFS_INTERRUPT_FLAGS    = 8'h05;
    localparam logic [7:0] OFS_CONVERTER_STATUS   = 8'h06;
    localparam logic [7:0] OFS_DEBUG_CONTROL      = 8'h07;
    localparam logic [7:0] OFS_SAMPLE_DURATION    = 8'h08;
    localparam logic [7:0] OFS_ACCUM_FORMAT_CTRL  = 8'h09;
    localparam logic [7:0] OFS_CONVERSION_COMMAND = 8'h0A;
    localparam logic [7:0] OFS_GAIN_AMP_CTRL      = 8'h0B;
    localparam logic [7:0] OFS_POS_INPUT_SELECT   = 8'h0C;
    localparam logic [7:0] OFS_NEG_INPUT_SELECT   = 8'h0D;
    localparam logic [7:0] OFS_ACCUM_RESULT       = 8'h10;
    localparam logic [7:0] OFS_LAST_SAMPLE        = 8'h14;
    localparam logic [7:0] OFS_SCRATCH_BYTE_0     = 8'h18;
    localparam logic [7:0] OFS_SCRATCH_BYTE_2     = 8'h1A;
    localparam logic [7:0] OFS_WINDOW_LOW_THR     = 8'h1C;
    localparam logic [7:0] OFS_WINDOW_HIGH_THR    = 8'h1E;

    localparam int unsigned ENABLE_BIT          = 0;
    localparam int unsigned KEEP_ANALOG_BIT     = 5;
    localparam int unsigned RUN_IN_STANDBY_BIT  = 7;
    localparam int unsigned RUN_DEBUG_BIT       = 0;
    localparam int unsigned FLAG_RESRDY_BIT     = 0;
    localparam int unsigned FLAG_SAMPRDY_BIT    = 1;
    localparam int unsigned FLAG_RESOVR_BIT     = 3;
    localparam int unsigned FLAG_SAMPOVR_BIT    = 4;
    localparam int unsigned FLAG_TRIGOVR_BIT    = 5;

    localparam logic [7:0] REG_RESET_VALUE      = 8'h00;
    localparam logic [7:0] MASK_CTRL_A          = 8'hA1;
    localparam logic [7:0] MASK_LOW_NIBBLE      = 8'h0F;
    localparam logic [7:0] MASK_INT_BITS        = 8'h3F;
    localparam logic [7:0] MASK_ONE_BIT         = 8'h01;
    localparam logic [7:0] MASK_FULL            = 8'hFF;
    localparam logic [7:0] MASK_NONE            = 8'h00;

    localparam logic [2:0] START_STOP           = 3'h0;
    localparam logic [2:0] START_IMMEDIATE      = 3'h1;
    localparam logic [2:0] START_EVENT_TRIGGER  = 3'h2;

    localparam int unsigned DEF_WARMUP_TICKS    = 4;
    localparam int unsigned DEF_CONV_TICKS      = 13;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_WARM = 2'b01,
        ST_CONV = 2'b11
    } asdc_state_t;

endpackage : asdc_pkg

// File: verilog/asdc_ctrl.sv
/*
 * asdc_ctrl: converter enable, clock divider, analog power policy,
 * sleep and debug-halt behaviour, start on event and register file.
 * Assumes all inputs synchronous to core_clk; sleep levels come from
 * the system sleep controller and stay high for the whole sleep.
 */
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - idle/standby sleep lets conversion finish first
// - idle sleep still accepts event-started conversions
// - standby event starts need run-in-standby bit
// - low-latency plus standby run keeps analog powered
// - powerdown aborts conversion and sleeps at once
// - debug run bit keeps converter working halted
// - halt without debug run finishes then stops
// - bit 7 lets converter run in standby
// - without low-latency power analog only per conversion
// - bit 5 keeps analog on while selected
// - bit 0 enables; reset leaves converter disabled
// - four-bit field divides clock two to sixtyfour
// - event edge starts only in event mode
module asdc_ctrl
    import asdc_pkg::*;
#(
    parameter int unsigned WARMUP_TICKS = asdc_pkg::DEF_WARMUP_TICKS,
    parameter int unsigned CONV_TICKS   = asdc_pkg::DEF_CONV_TICKS
)
(
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [7:0]  reg_rdata,
    input  wire logic        sleep_idle,
    input  wire logic        sleep_standby,
    input  wire logic        sleep_powerdown,
    input  wire logic        debug_halt,
    input  wire logic        start_event,
    input  wire logic [15:0] sample_in,
    output var  logic        adc_clk_tick,
    output var  logic        analog_power_on,
    output var  logic        conversion_in_progress,
    output var  logic        converter_stopped,
    output var  logic        irq
);
    import asdc_pkg::*;

    logic [7:0]  cfg_mem [0:31];
    logic [7:0]  flags_reg;
    logic [7:0]  flags_next;
    logic [15:0] sample_reg;
    logic        event_prev_reg;
    logic [6:0]  div_cnt_reg;
    logic [6:0]  div_cnt_next;
    logic [7:0]  step_cnt_reg;
    logic [7:0]  step_cnt_next;
    asdc_state_t state_reg;
    asdc_state_t state_next;

    wire logic [4:0] addr_idx   = reg_addr[4:0];
    wire logic       addr_low   = (reg_addr[7:5] == 3'h0);
    wire logic [7:0] ctrl_a     = cfg_mem[OFS_CTRL_ENABLE_SLEEP[4:0]];
    wire logic [3:0] div_select =
        cfg_mem[OFS_CLOCK_DIVIDER_CTRL[4:0]][3:0];
    wire logic [2:0] start_mode =
        cfg_mem[OFS_CONVERSION_COMMAND[4:0]][2:0];
    wire logic [7:0] int_enable = cfg_mem[OFS_INTERRUPT_ENABLE[4:0]];

    wire logic ctrl_en         = ctrl_a[ENABLE_BIT];
    wire logic keep_analog_powered = ctrl_a[KEEP_ANALOG_BIT];
    wire logic run_in_standby  = ctrl_a[RUN_IN_STANDBY_BIT];
    wire logic run_while_debug_halted =
        cfg_mem[OFS_DEBUG_CONTROL[4:0]][RUN_DEBUG_BIT];

    // divider ratio: 2..16 step 2, 20..32 step 4, 40..64 step 8
    // prescaler ratio decode
    wire logic [6:0] div_ratio =
        (div_select < 4'h8) ? {2'b00, div_select, 1'b0} + 7'h02 :
        (div_select < 4'hC) ? {1'b0, div_select, 2'b00} - 7'h0C :
                              {div_select[2:0], 3'b000} + 7'h08;

    // standby and halt stop the converter unless told to run
    // standby gate
    wire logic standby_stop = sleep_standby & ~run_in_standby;
    wire logic halt_stop    = debug_halt & ~run_while_debug_halted;
    wire logic no_new_start =
        ~ctrl_en | sleep_powerdown | standby_stop | halt_stop;

    wire logic event_rise = start_event & ~event_prev_reg;
    wire logic wr_command =
        reg_wr & (reg_addr == OFS_CONVERSION_COMMAND);
    wire logic sw_trigger =
        wr_command & (reg_wdata[2:0] == START_IMMEDIATE);
    // event starts also in idle sleep
    // events in standby only with run bit
    wire logic ev_trigger =
        event_rise & (start_mode == START_EVENT_TRIGGER);
    wire logic trigger   = (sw_trigger | ev_trigger) & ~no_new_start;
    wire logic busy      = (state_reg != ST_IDLE);
    wire logic start_now = trigger & ~busy;
    wire logic trig_ovr  = trigger & busy;

    // divided converter clock
    // a smaller new divide ticks at once instead of wrapping the counter
    wire logic tick_now  = ctrl_en & (div_cnt_reg >= div_ratio - 7'h01);
    wire logic warm_last =
        tick_now & (step_cnt_reg == 8'(WARMUP_TICKS - 1));
    wire logic conv_last =
        tick_now & (step_cnt_reg == 8'(CONV_TICKS - 1));
    wire logic abort_now = busy & (sleep_powerdown | ~ctrl_en);
    wire logic conv_done = (state_reg == ST_CONV) & conv_last & ~abort_now;

    wire logic wr_flags = reg_wr & (reg_addr == OFS_INTERRUPT_FLAGS);
    wire logic [7:0] wr_mask =
        (!addr_low) ? MASK_NONE :
        (reg_addr == OFS_CTRL_ENABLE_SLEEP) ? MASK_CTRL_A :
        (reg_addr == OFS_CLOCK_DIVIDER_CTRL) ? MASK_LOW_NIBBLE :
        (reg_addr == OFS_WINDOW_CMP_CTRL) ? MASK_LOW_NIBBLE :
        (reg_addr == OFS_INTERRUPT_ENABLE) ? MASK_INT_BITS :
        (reg_addr == OFS_DEBUG_CONTROL) ? MASK_ONE_BIT :
        (reg_addr == OFS_TIMEBASE_REF_CTRL) ? MASK_FULL :
        (reg_addr >= OFS_SAMPLE_DURATION &&
         reg_addr <= OFS_NEG_INPUT_SELECT) ? MASK_FULL :
        (reg_addr >= OFS_SCRATCH_BYTE_0 &&
         reg_addr <= OFS_SCRATCH_BYTE_2) ? MASK_FULL :
        (reg_addr >= OFS_WINDOW_LOW_THR &&
         reg_addr <= OFS_WINDOW_HIGH_THR + 8'h01) ? MASK_FULL :
                                           MASK_NONE;

    wire logic [7:0] status_byte = {7'h00, conversion_in_progress};
    wire logic [7:0] rd_mux;
    assign rd_mux =
        (!addr_low) ? 8'h00 :
        (reg_addr == OFS_INTERRUPT_FLAGS) ? flags_reg :
        (reg_addr == OFS_CONVERTER_STATUS) ? status_byte :
        (reg_addr == OFS_ACCUM_RESULT) ? sample_reg[7:0] :
        (reg_addr == OFS_ACCUM_RESULT + 8'h01) ? sample_reg[15:8] :
        (reg_addr == OFS_LAST_SAMPLE) ? sample_reg[7:0] :
        (reg_addr == OFS_LAST_SAMPLE + 8'h01) ? sample_reg[15:8] :
        (wr_mask != MASK_NONE) ? cfg_mem[addr_idx] :
                                 8'h00;

    // flags: hardware set wins over a software clear in the same cycle
    wire logic [7:0] flag_set =
        ({7'h00, trig_ovr} << FLAG_TRIGOVR_BIT) |
        ({7'h00, conv_done & flags_reg[FLAG_SAMPRDY_BIT]}
            << FLAG_SAMPOVR_BIT) |
        ({7'h00, conv_done & flags_reg[FLAG_RESRDY_BIT]}
            << FLAG_RESOVR_BIT) |
        ({7'h00, conv_done} << FLAG_SAMPRDY_BIT) |
        ({7'h00, conv_done} << FLAG_RESRDY_BIT);
    wire logic [7:0] flag_clr =
        wr_flags ? (reg_wdata & MASK_INT_BITS) : 8'h00;
    assign flags_next = ((flags_reg & ~flag_clr) | flag_set)
                        & MASK_INT_BITS;

    always_comb
    begin
        state_next    = state_reg;
        step_cnt_next = step_cnt_reg;
        case (state_reg)
            ST_IDLE:
            begin
                step_cnt_next = 8'h00;
                if (start_now && analog_power_on)
                begin
                    state_next = ST_CONV;
                end
                else if (start_now)
                begin
                    state_next = ST_WARM;
                end
            end
            ST_WARM:
            begin
                if (abort_now)
                begin
                    state_next    = ST_IDLE;
                    step_cnt_next = 8'h00;
                end
                else if (warm_last)
                begin
                    state_next    = ST_CONV;
                    step_cnt_next = 8'h00;
                end
                else if (tick_now)
                begin
                    step_cnt_next = step_cnt_reg + 8'h01;
                end
            end
            ST_CONV:
            begin
                // idle/standby do not cut a conversion
                if (abort_now || conv_last)
                begin
                    state_next    = ST_IDLE;
                    step_cnt_next = 8'h00;
                end
                else if (tick_now)
                begin
                    step_cnt_next = step_cnt_reg + 8'h01;
                end
            end
            default:
            begin
                state_next    = ST_IDLE;
                step_cnt_next = 8'h00;
            end
        endcase
    end

    assign div_cnt_next = (!ctrl_en || tick_now) ? 7'h00
                                                 : div_cnt_reg + 7'h01;

    // standby with both bits keeps analog on
    // low-latency holds analog on while enabled, except in powerdown, in standby without run bit or in halt without debug run
    wire logic analog_next = ctrl_en & ~sleep_powerdown &
        ((state_next != ST_IDLE) |
         (keep_analog_powered & ~standby_stop & ~halt_stop));
    wire logic stopped_next = (state_next == ST_IDLE) &
        (~ctrl_en | sleep_powerdown | standby_stop | halt_stop);

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_reg      <= ST_IDLE;
            step_cnt_reg   <= 8'h00;
            div_cnt_reg    <= 7'h00;
            event_prev_reg <= 1'b0;
            flags_reg      <= REG_RESET_VALUE;
            sample_reg     <= 16'h0000;
        end
        else
        begin
            state_reg      <= state_next;
            step_cnt_reg   <= step_cnt_next;
            div_cnt_reg    <= div_cnt_next;
            event_prev_reg <= start_event;
            flags_reg      <= flags_next;
            if (conv_done)
            begin
                sample_reg <= sample_in;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        for (int i = 0; i < 32; i++)
        begin
            if (srst)
            begin
                cfg_mem[i] <= REG_RESET_VALUE;
            end
            else if (reg_wr && addr_idx == 5'(i))
            begin
                cfg_mem[i] <= (cfg_mem[i] & ~wr_mask) |
                              (reg_wdata & wr_mask);
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            reg_rdata              <= 8'h00;
            adc_clk_tick           <= 1'b0;
            analog_power_on        <= 1'b0;
            conversion_in_progress <= 1'b0;
            converter_stopped      <= 1'b1;
            irq                    <= 1'b0;
        end
        else
        begin
            reg_rdata              <= reg_rd ? rd_mux : 8'h00;
            adc_clk_tick           <= tick_now;
            analog_power_on        <= analog_next;
            conversion_in_progress <= (state_next != ST_IDLE);
            converter_stopped      <= stopped_next;
            irq                    <= |(flags_next & int_enable);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    chk_powerdown_abort: assert property (
        busy && sleep_powerdown |=> state_reg == ST_IDLE
            && !conversion_in_progress && !analog_power_on)
        else $error("conversion not aborted on powerdown");

    chk_sleep_finish: assert property (
        state_reg == ST_CONV && ctrl_en && !sleep_powerdown
            && !conv_last && (sleep_idle || sleep_standby)
        |=> state_reg == ST_CONV)
        else $error("conversion cut short by idle or standby");

    chk_idle_event: assert property (
        sleep_idle && ev_trigger && !no_new_start && !busy
        |=> conversion_in_progress)
        else $error("event start lost in idle sleep");

    chk_standby_block: assert property (
        !busy && sleep_standby && !run_in_standby
        |=> !conversion_in_progress)
        else $error("conversion started in standby without run bit");

    chk_keep_analog_powered_on: assert property (
        ctrl_en && keep_analog_powered && run_in_standby
            && sleep_standby && !sleep_powerdown && !halt_stop
        |=> analog_power_on)
        else $error("analog off in standby with low latency");

    chk_keep_analog_powered_off: assert property (
        !busy && !start_now && !keep_analog_powered
        |=> !analog_power_on)
        else $error("analog powered while idle without low latency");

    chk_debug_run: assert property (
        debug_halt && run_while_debug_halted && (sw_trigger || ev_trigger)
            && !no_new_start && !busy
        |=> conversion_in_progress)
        else $error("converter stalled in debug with run bit");

    chk_halt_stop: assert property (
        !busy && halt_stop |=> !conversion_in_progress)
        else $error("converter started while debug halted");

    chk_disabled_idle: assert property (
        !ctrl_en |=> !conversion_in_progress && !analog_power_on)
        else $error("converter active while disabled");

    chk_divider_span: assert property (
        adc_clk_tick |-> ##1 !adc_clk_tick)
        else $error("converter clock faster than divide by two");

    chk_event_mode: assert property (
        event_rise && start_mode != START_EVENT_TRIGGER
            && !sw_trigger && !busy
        |=> !conversion_in_progress)
        else $error("event started conversion outside event mode");

    chk_busy_bit: assert property (
        conversion_in_progress == busy)
        else $error("busy bit out of step with conversion");

    cov_conversion_done: cover property (conv_done);
    cov_powerdown_abort: cover property (busy && sleep_powerdown);
    cov_trigger_overrun: cover property (trig_ovr);
    cov_standby_event: cover property (
        sleep_standby && run_in_standby && ev_trigger && !busy);

endmodule : asdc_ctrl

`default_nettype wire

// File: dv/asdc_sys_model.sv
/*
 * asdc_sys_model: system side of the converter control block: sleep
 * controller, debug halt and event generator, steered by the bench.
 * Assumes bench requests change just after a rising core_clk edge.
 */
`timescale 1ns/1ps
`default_nettype none
module asdc_sys_model
(
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic [1:0] mode_req,
    input  wire logic       halt_req,
    input  wire logic       event_req,
    input  wire logic       drain_first,
    input  wire logic       busy,
    output var  logic       sleep_idle,
    output var  logic       sleep_standby,
    output var  logic       sleep_powerdown,
    output var  logic       debug_halt,
    output var  logic       start_event
);
    logic ev_hold_reg;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            sleep_idle      <= 1'b0;
            sleep_standby   <= 1'b0;
            sleep_powerdown <= 1'b0;
            debug_halt      <= 1'b0;
            start_event     <= 1'b0;
            ev_hold_reg     <= 1'b0;
        end
        else
        begin
            sleep_idle    <= (mode_req == 2'h1);
            sleep_standby <= (mode_req == 2'h2);
            if (mode_req != 2'h3)
                sleep_powerdown <= 1'b0;
            else if (!drain_first || !busy)
                sleep_powerdown <= 1'b1;
            debug_halt  <= halt_req;
            // event held two cycles so the edge is clean
            ev_hold_reg <= event_req;
            start_event <= event_req | ev_hold_reg;
        end
    end
endmodule : asdc_sys_model
`default_nettype wire

// File: dv/asdc_ctrl_tb.sv
/*
 * asdc_ctrl_tb: self-checking bench for asdc_ctrl and the system model.
 * Assumes short warm-up and conversion counts set by parameter.
 */
`timescale 1ns/1ps
`default_nettype none
module asdc_ctrl_tb;
    import asdc_pkg::*;
    logic        core_clk;
    logic        srst;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [15:0] sample_in;
    logic [1:0]  mode_req;
    logic        halt_req;
    logic        event_req;
    logic        drain_first;
    logic        s_idle;
    logic        s_stby;
    logic        s_pdn;
    logic        dbg_halt;
    logic        start_event;
    logic        adc_clk_tick;
    logic        analog_power_on;
    logic        busy;
    logic        converter_stopped;
    logic        irq;
    int          err_count;
    int          checks_done;

    asdc_ctrl #(.WARMUP_TICKS(1), .CONV_TICKS(2)) u_dut
    (
        .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sleep_idle(s_idle),
        .sleep_standby(s_stby), .sleep_powerdown(s_pdn),
        .debug_halt(dbg_halt), .start_event(start_event),
        .sample_in(sample_in), .adc_clk_tick(adc_clk_tick),
        .analog_power_on(analog_power_on),
        .conversion_in_progress(busy),
        .converter_stopped(converter_stopped), .irq(irq)
    );

    asdc_sys_model u_sys
    (
        .core_clk(core_clk), .srst(srst), .mode_req(mode_req),
        .halt_req(halt_req), .event_req(event_req),
        .drain_first(drain_first), .busy(busy), .sleep_idle(s_idle),
        .sleep_standby(s_stby), .sleep_powerdown(s_pdn),
        .debug_halt(dbg_halt), .start_event(start_event)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string m);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h",
                     $time, m, got, exp);
        end
    endtask : check

    task automatic bit_is(input logic got, input logic exp, input string m);
        check({7'h0, got}, {7'h0, exp}, m);
    endtask : bit_is

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // idle cycle so a following write always re-raises the strobe
        @(posedge core_clk);
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                      input string m);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        check(reg_rdata, exp, m);
    endtask : rd

    task automatic ev();
        event_req <= 1'b1;
        @(posedge core_clk);
        event_req <= 1'b0;
    endtask : ev

    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (busy !== lvl && n < lim)
        begin
            @(posedge core_clk);
            n++;
        end
        bit_is(busy, lvl, "busy level");
    endtask : wait_busy

    task automatic t_reset();
        bit_is(converter_stopped, 1'b1, "reset stop");
        bit_is(irq, 1'b0, "reset irq");
        rd(8'h00, 8'h00, "ctrl a");
        rd(8'h01, 8'h00, "ctrl b");
        wr(8'h06, 8'hFF);
        rd(8'h06, 8'h00, "status ro");
        rd(8'h0E, 8'h00, "unmapped");
        wr(8'h00, 8'hFE);
        rd(8'h00, 8'hA0, "ctrl a mask");
        bit_is(analog_power_on, 1'b0, "off disabled");
        wr(8'h07, 8'hFF);
        rd(8'h07, 8'h01, "dbg mask");
        wr(8'h07, 8'h00);
        wr(8'h00, 8'h01);
    endtask : t_reset

    // second gap between ticks, after the new divide has settled
    task automatic t_divider();
        int n;
        int e;
        for (int k = 0; k < 16; k++)
        begin
            wr(8'h01, k[7:0]);
            repeat (3)
            begin
                n = 0;
                while (adc_clk_tick !== 1'b1 && n < 200)
                begin
                    @(posedge core_clk);
                    n++;
                end
                @(posedge core_clk);
            end
            e = (k < 8) ? 2 * (k + 1) : (k < 12) ? 4 * k - 12 : 8 * k - 56;
            check(8'(n + 1), 8'(e), "divide");
        end
        wr(8'h01, 8'h00);
    endtask : t_divider

    task automatic t_conv();
        wr(8'h04, 8'h03);
        sample_in <= 16'h1234;
        wr(8'h0A, 8'h01);
        cyc(1);
        bit_is(busy, 1'b1, "busy rise");
        bit_is(analog_power_on, 1'b1, "power on start");
        wait_busy(1'b0, 40);
        cyc(1);
        bit_is(analog_power_on, 1'b0, "power off after");
        bit_is(irq, 1'b1, "irq set");
        rd(8'h05, 8'h03, "ready flags");
        rd(8'h14, 8'h34, "sample lo");
        rd(8'h15, 8'h12, "sample hi");
        rd(8'h10, 8'h34, "result lo");
        wr(8'h04, 8'h00);
        cyc(2);
        bit_is(irq, 1'b0, "irq masked");
        sample_in <= 16'hA55A;
        wr(8'h0A, 8'h01);
        wait_busy(1'b1, 4);
        wait_busy(1'b0, 40);
        rd(8'h05, 8'h1B, "overwrite flags");
        rd(8'h15, 8'hA5, "sample two");
        wr(8'h04, 8'h3F);
        cyc(2);
        bit_is(irq, 1'b1, "irq enabled");
        wr(8'h05, 8'hFF);
        cyc(2);
        bit_is(irq, 1'b0, "irq cleared");
        rd(8'h05, 8'h00, "flags cleared");
        wr(8'h04, 8'h00);
    endtask : t_conv

    task automatic t_event();
        wr(8'h01, 8'h01);
        wr(8'h0A, 8'h00);
        ev();
        cyc(6);
        bit_is(busy, 1'b0, "stop mode");
        wr(8'h0A, 8'h02);
        ev();
        wait_busy(1'b1, 5);
        ev();
        wait_busy(1'b0, 40);
        rd(8'h05, 8'h23, "trig overrun");
        wr(8'h05, 8'hFF);
    endtask : t_event

    task automatic t_sleep();
        mode_req <= 2'h1;
        cyc(2);
        ev();
        wait_busy(1'b1, 5);
        wait_busy(1'b0, 40);
        wr(8'h05, 8'hFF);
        mode_req <= 2'h0;
        ev();
        wait_busy(1'b1, 5);
        mode_req <= 2'h2;
        wait_busy(1'b0, 40);
        rd(8'h05, 8'h03, "finish first");
        wr(8'h05, 8'hFF);
        ev();
        cyc(6);
        bit_is(busy, 1'b0, "standby block");
        bit_is(converter_stopped, 1'b1, "standby stop");
        wr(8'h00, 8'hA1);
        cyc(2);
        bit_is(analog_power_on, 1'b1, "standby power");
        ev();
        wait_busy(1'b1, 5);
        wait_busy(1'b0, 40);
        mode_req <= 2'h0;
        wr(8'h00, 8'h21);
        cyc(2);
        bit_is(analog_power_on, 1'b1, "low latency");
        wr(8'h00, 8'h01);
        cyc(2);
        bit_is(analog_power_on, 1'b0, "no low latency");
        wr(8'h05, 8'hFF);
    endtask : t_sleep

    task automatic t_pdown();
        drain_first <= 1'b0;
        ev();
        wait_busy(1'b1, 5);
        mode_req <= 2'h3;
        wait_busy(1'b0, 4);
        rd(8'h05, 8'h00, "aborted");
        bit_is(converter_stopped, 1'b1, "pd stop");
        mode_req    <= 2'h0;
        drain_first <= 1'b1;
        cyc(2);
    endtask : t_pdown

    task automatic t_debug();
        ev();
        wait_busy(1'b1, 5);
        halt_req <= 1'b1;
        wait_busy(1'b0, 40);
        rd(8'h05, 8'h03, "halt finish");
        bit_is(converter_stopped, 1'b1, "halt stop");
        ev();
        cyc(6);
        bit_is(busy, 1'b0, "halt block");
        wr(8'h07, 8'h01);
        ev();
        wait_busy(1'b1, 5);
        wait_busy(1'b0, 40);
        rd(8'h05, 8'h1B, "halt run");
        halt_req <= 1'b0;
    endtask : t_debug

    initial
    begin
        #1000000;
        err_count++;
        give_verdict();
    end

    initial
    begin
        srst        = 1'b1;
        reg_addr    = 8'h00;
        reg_wdata   = 8'h00;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        sample_in   = 16'h0000;
        mode_req    = 2'h0;
        halt_req    = 1'b0;
        event_req   = 1'b0;
        drain_first = 1'b1;
        err_count   = 0;
        checks_done = 0;
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_divider();
        t_conv();
        t_event();
        t_sleep();
        t_pdown();
        t_debug();
        give_verdict();
    end
endmodule : asdc_ctrl_tb
`default_nettype wire
